// [src/clock_mode_sequencer.sv]
//
// Overview of operation
// - Source field value 10 routes the external reference to the generator output.
// - Source field value 01 routes the internal reference to the generator output.
// - Source field value 00 routes the loop: FLL if loop select 0, PLL if 1.
// - Reference divider field divides by two to the power of its code.
// - Reference select bit clear picks external reference, set picks internal.
// - Bus divider field in second register, code 00 divides by one.
// - Second register bit 5 selects high range, bit 4 selects high gain.
// - Crystal bit set selects a crystal so oscillator initialization runs.
// - External clock enable bit keeps the external reference active.
// - In bypassed external mode, low-power bit enters or leaves low-power bypass.
// - Low-power bypass disables both loops and defers divider, multiplier, select writes.
// - Third register bit 6 picks PLL or FLL; multiplier ignored under FLL.
// - Multiplier field code 0100 multiplies the divided reference by 16.
// - Oscillator-init status sets once the selected crystal has stabilized.
// - Reference status bit shows the loop reference actually in use.
// - Source status bits report the source actually feeding the output.
// - Loop status bit set when PLL feeds the loop clock, clear for FLL.
// - Lock status bit set once the selected loop has locked.
// - FLL stays enabled in non-low-power FLL bypass modes while loop select is clear.
// - Engaged PLL output is ext over divider times multiplier over bus divider.
// - Reset starts in FLL engaged internal mode with bus divide-by-2.
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps

`include "clock_mode_consts.svh"

module clock_mode_sequencer (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       osc_stable,
    input  wire logic                       fll_locked,
    input  wire logic                       pll_locked,
    output logic      [1:0]                 generator_source,
    output logic                            loop_ref_internal,
    output logic                            fll_enable,
    output logic                            pll_enable,
    output logic      [7:0]                 ref_divide_ratio,
    output logic      [7:0]                 pll_mult_factor,
    output logic      [1:0]                 bus_divider,
    output logic                            osc_high_range,
    output logic                            osc_high_gain,
    output logic                            ext_source_crystal,
    output logic                            ext_refclk_active,
    output clock_mode_pkg::clock_mode_e     clock_mode
);

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] actual_source(input logic [1:0] sel, input logic pll);
        if (sel == `SRC_EXTERNAL) begin
            actual_source = `SRC_EXTERNAL;
        end else if (sel == `SRC_INTERNAL) begin
            actual_source = `SRC_INTERNAL;
        end else if (pll) begin
            actual_source = `SRC_PLL_STAT;
        end else begin
            actual_source = `SRC_LOOP;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    clock_mode_pkg::seq_state_s q;
    clock_mode_pkg::seq_state_s d;

    logic [1:0]  src_sel;
    logic        lp_active;
    logic [1:0]  src_target;
    logic        lock_now;
    logic        osc_init_done_now;
    logic [7:0]  status_byte;
    logic        acc;
    logic [31:0] rd_word;
    logic        rd_err;

    always_comb begin
        d = q;

        src_sel = q.source_div[`SRC_SEL_HI:`SRC_SEL_LO];
        // Low power only exists in the bypass modes
        lp_active = q.osc_bus[`LP_BIT] && (src_sel != `SRC_LOOP);

        // Deferred loop settings: frozen while low-power bypass holds
        if (!lp_active) begin
            d.loop_sel_eff = q.loop_mult[`LOOP_SEL_BIT];
            d.reference_divider_eff     = q.source_div[`REFERENCE_DIVIDER_HI:`REFERENCE_DIVIDER_LO];
            d.pll_multiplier_eff     = q.loop_mult[`PLL_MULTIPLIER_HI:`PLL_MULTIPLIER_LO];
        end

        d.fll_en = !lp_active && !q.loop_sel_eff;
        d.pll_en = !lp_active && q.loop_sel_eff;
        d.ref_ratio = 8'h01 << q.reference_divider_eff;
        // Multiplier meaningless while FLL is selected
        d.mult_factor = q.loop_sel_eff ? {2'h0, q.pll_multiplier_eff, 2'h0} : 8'h00;
        d.ext_ref_on = q.osc_bus[`EXT_REFCLK_ENABLE_BIT] || !q.source_div[`IREF_SEL_BIT]
                       || (src_sel == `SRC_EXTERNAL);

        src_target = (src_sel == 2'h3) ? q.src_stat : actual_source(src_sel, q.loop_sel_eff);

        // Status follows only after the mux has had time to switch
        if (src_target != q.src_stat || q.source_div[`IREF_SEL_BIT] != q.iref_stat
            || q.loop_sel_eff != q.loop_stat) begin
            if (q.settle == 4'((`SWITCH_CYCLES) - 1)) begin
                d.settle    = 4'h0;
                d.src_stat  = src_target;
                d.iref_stat = q.source_div[`IREF_SEL_BIT];
                d.loop_stat = q.loop_sel_eff;
            end else begin
                d.settle = q.settle + 4'h1;
            end
        end else begin
            d.settle = 4'h0;
        end

        // Mode derived from the actual state of the mux
        if (q.src_stat == `SRC_INTERNAL) begin
            d.mode = lp_active ? clock_mode_pkg::lowpower_bypass_internal
                               : clock_mode_pkg::fll_bypassed_internal;
        end else if (q.src_stat == `SRC_EXTERNAL) begin
            if (lp_active) begin
                d.mode = clock_mode_pkg::lowpower_bypass_external;
            end else if (q.loop_stat) begin
                d.mode = clock_mode_pkg::pll_bypassed_external;
            end else begin
                d.mode = clock_mode_pkg::fll_bypassed_external;
            end
        end else if (q.src_stat == `SRC_PLL_STAT) begin
            d.mode = q.iref_stat ? clock_mode_pkg::mode_unsupported
                                 : clock_mode_pkg::pll_engaged_external;
        end else begin
            d.mode = q.iref_stat ? clock_mode_pkg::fll_engaged_internal
                                 : clock_mode_pkg::fll_engaged_external;
        end

        lock_now = (q.fll_en && !q.loop_stat && fll_locked)
                   || (q.pll_en && q.loop_stat && pll_locked);
        osc_init_done_now = q.osc_bus[`CRYSTAL_BIT] && osc_stable;

        status_byte = 8'h00;
        status_byte[`ST_LOCK_BIT]           = lock_now;
        status_byte[`ST_LOOP_BIT]           = q.loop_stat;
        status_byte[`ST_IREF_BIT]           = q.iref_stat;
        status_byte[`ST_SRC_HI:`ST_SRC_LO]  = q.src_stat;
        status_byte[`ST_OSC_INIT_DONE_BIT]        = osc_init_done_now;

        // APB: one wait state, then the access completes
        acc = psel && penable && q.pready;
        d.pready  = psel && penable && !q.pready;
        d.pslverr = 1'b0;
        rd_err    = 1'b0;
        rd_word   = 32'h0000_0000;
        if (paddr == `OFS_SOURCE_DIV) begin
            rd_word = {24'h000000, q.source_div};
        end else if (paddr == `OFS_OSC_BUS) begin
            rd_word = {24'h000000, q.osc_bus};
        end else if (paddr == `OFS_LOOP_MULT) begin
            rd_word = {24'h000000, q.loop_mult};
        end else if (paddr == `OFS_GEN_STATUS) begin
            rd_word = {24'h000000, status_byte};
        end else begin
            rd_err = 1'b1;
        end
        if (psel && penable && !q.pready) begin
            d.prdata  = pwrite ? 32'h0000_0000 : rd_word;
            d.pslverr = rd_err;
        end
        if (acc && pwrite) begin
            if (paddr == `OFS_SOURCE_DIV) begin
                d.source_div = pwdata[7:0];
            end else if (paddr == `OFS_OSC_BUS) begin
                d.osc_bus = pwdata[7:0];
            end else if (paddr == `OFS_LOOP_MULT) begin
                d.loop_mult = pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.source_div   <= `RST_SOURCE_DIV;
            q.osc_bus      <= `RST_OSC_BUS;
            q.loop_mult    <= `RST_LOOP_MULT;
            q.loop_sel_eff <= 1'b0;
            q.reference_divider_eff     <= 3'h0;
            q.pll_multiplier_eff     <= 4'h1;
            q.iref_stat    <= 1'b1;
            q.src_stat     <= `SRC_LOOP;
            q.loop_stat    <= 1'b0;
            q.settle       <= 4'h0;
            q.fll_en       <= 1'b1;
            q.pll_en       <= 1'b0;
            q.ext_ref_on   <= 1'b0;
            q.ref_ratio    <= 8'h01;
            q.mult_factor  <= 8'h00;
            q.mode         <= clock_mode_pkg::fll_engaged_internal;
            q.prdata       <= 32'h0000_0000;
            q.pready       <= 1'b0;
            q.pslverr      <= 1'b0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign prdata             = q.prdata;
    assign pready             = q.pready;
    assign pslverr            = q.pslverr;
    assign generator_source   = q.src_stat;
    assign loop_ref_internal  = q.iref_stat;
    assign fll_enable         = q.fll_en;
    assign pll_enable         = q.pll_en;
    assign ref_divide_ratio   = q.ref_ratio;
    assign pll_mult_factor    = q.mult_factor;
    assign bus_divider        = q.osc_bus[`BUS_DIVIDER_HI:`BUS_DIVIDER_LO];
    assign osc_high_range     = q.osc_bus[`RANGE_BIT];
    assign osc_high_gain      = q.osc_bus[`HGO_BIT];
    assign ext_source_crystal = q.osc_bus[`CRYSTAL_BIT];
    assign ext_refclk_active  = q.ext_ref_on;
    assign clock_mode         = q.mode;

endmodule

// [src/clock_mode_consts.svh]
`ifndef CLOCK_MODE_CONSTS_SVH
`define CLOCK_MODE_CONSTS_SVH

// Register byte offsets
`define OFS_SOURCE_DIV      8'h00
`define OFS_OSC_BUS         8'h04
`define OFS_LOOP_MULT       8'h08
`define OFS_GEN_STATUS      8'h0C

// Reset values: internal reference, loop output, bus divide-by-2
`define RST_SOURCE_DIV      8'h04
`define RST_OSC_BUS         8'h40
`define RST_LOOP_MULT       8'h01
`define RST_GEN_STATUS      8'h10

// First control register fields
`define SRC_SEL_HI          7
`define SRC_SEL_LO          6
`define REFERENCE_DIVIDER_HI             5
`define REFERENCE_DIVIDER_LO             3
`define IREF_SEL_BIT        2

// Second control register fields
`define BUS_DIVIDER_HI             7
`define BUS_DIVIDER_LO             6
`define RANGE_BIT           5
`define HGO_BIT             4
`define LP_BIT              3
`define CRYSTAL_BIT         2
`define EXT_REFCLK_ENABLE_BIT         1

// Third control register fields
`define LOOP_SEL_BIT        6
`define PLL_MULTIPLIER_HI             3
`define PLL_MULTIPLIER_LO             0

// Status fields
`define ST_LOCK_BIT         6
`define ST_LOOP_BIT         5
`define ST_IREF_BIT         4
`define ST_SRC_HI           3
`define ST_SRC_LO           2
`define ST_OSC_INIT_DONE_BIT      1

// Source select and status codes
`define SRC_LOOP            2'h0
`define SRC_INTERNAL        2'h1
`define SRC_EXTERNAL        2'h2
`define SRC_PLL_STAT        2'h3

// Switch settling time
`define SWITCH_NS           200
`define CLK_PERIOD_NS       40
`define SWITCH_CYCLES       ((`SWITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [src/clock_mode_pkg.sv]
package clock_mode_pkg;

    typedef enum logic [3:0] {
        fll_engaged_internal     = 4'h0,
        fll_engaged_external     = 4'h1,
        fll_bypassed_internal    = 4'h2,
        fll_bypassed_external    = 4'h3,
        pll_engaged_external     = 4'h4,
        pll_bypassed_external    = 4'h5,
        lowpower_bypass_internal = 4'h6,
        lowpower_bypass_external = 4'h7,
        mode_unsupported         = 4'h8
    } clock_mode_e;

    typedef struct packed {
        logic [7:0]  source_div;
        logic [7:0]  osc_bus;
        logic [7:0]  loop_mult;
        logic        loop_sel_eff;
        logic [2:0]  reference_divider_eff;
        logic [3:0]  pll_multiplier_eff;
        logic        iref_stat;
        logic [1:0]  src_stat;
        logic        loop_stat;
        logic [3:0]  settle;
        logic        fll_en;
        logic        pll_en;
        logic        ext_ref_on;
        logic [7:0]  ref_ratio;
        logic [7:0]  mult_factor;
        clock_mode_e mode;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } seq_state_s;

endpackage

// [testbench/clock_mode_props.sv]
`timescale 1ns/1ps
`include "clock_mode_consts.svh"
module clock_mode_props (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [7:0]                  paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [1:0]                  bus_divider,
    input wire logic                        osc_high_gain,
    input wire logic                        fll_enable,
    input wire logic                        pll_enable,
    input wire logic [1:0]                  generator_source,
    input wire logic                        loop_ref_internal,
    input wire logic [7:0]                  pll_mult_factor,
    input wire clock_mode_pkg::clock_mode_e clock_mode
);
////////////////////////////////////////////////////////////////////////
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
pready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no answer after wait state");
slverr_map_a: assert property (psel && penable && pready |-> pslverr == !(paddr == `OFS_SOURCE_DIV
    || paddr == `OFS_OSC_BUS || paddr == `OFS_LOOP_MULT || paddr == `OFS_GEN_STATUS))
    else $error("error response wrong for address");
osc_field_a: assert property (psel && penable && pready && pwrite && paddr == `OFS_OSC_BUS
    |-> ##2 bus_divider == $past(pwdata[7:6], 2) && osc_high_gain == $past(pwdata[4], 2))
    else $error("second control fields not applied");
pee_src_a: assert property (clock_mode == clock_mode_pkg::pll_engaged_external
    |-> $past(generator_source) == 2'h3 && !$past(loop_ref_internal)) else $error("engaged loop source wrong");
fbi_src_a: assert property (clock_mode == clock_mode_pkg::fll_bypassed_internal
    |-> $past(generator_source) == 2'h1 && $past(loop_ref_internal)) else $error("internal bypass source wrong");
lowpower_bypass_external_off_a: assert property ((clock_mode == clock_mode_pkg::lowpower_bypass_external)[*3]
    |-> !fll_enable && !pll_enable) else $error("loop enabled in low power");
fei_mult_a: assert property (clock_mode == clock_mode_pkg::fll_engaged_internal
    |-> pll_mult_factor == 8'h00) else $error("multiplier active under fll");
endmodule

bind clock_mode_sequencer clock_mode_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .bus_divider(bus_divider), .osc_high_gain(osc_high_gain), .fll_enable(fll_enable), .pll_enable(pll_enable),
    .generator_source(generator_source), .loop_ref_internal(loop_ref_internal),
    .pll_mult_factor(pll_mult_factor), .clock_mode(clock_mode));

// [testbench/tb.sv]
`timescale 1ns/1ps
`include "clock_mode_consts.svh"
`define chk(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
logic                        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
logic                        osc_stable, fll_locked, pll_locked, loop_ref_internal, fll_enable, pll_enable;
logic                        osc_high_range, osc_high_gain, ext_source_crystal, ext_refclk_active;
logic [7:0]                  paddr, ref_divide_ratio, pll_mult_factor;
logic [31:0]                 pwdata, prdata, rd;
logic [1:0]                  generator_source, bus_divider;
clock_mode_pkg::clock_mode_e clock_mode;
int                          error_cnt, compares;
clock_mode_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_stable(osc_stable),
    .fll_locked(fll_locked), .pll_locked(pll_locked), .generator_source(generator_source),
    .loop_ref_internal(loop_ref_internal), .fll_enable(fll_enable), .pll_enable(pll_enable),
    .ref_divide_ratio(ref_divide_ratio), .pll_mult_factor(pll_mult_factor), .bus_divider(bus_divider),
    .osc_high_range(osc_high_range), .osc_high_gain(osc_high_gain), .ext_source_crystal(ext_source_crystal),
    .ext_refclk_active(ext_refclk_active), .clock_mode(clock_mode));
////////////////////////////////////////////////////////////////////////
initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
end
task stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
// Read right after the edge: flops update later in that step, so this is the sampled value
task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin @(posedge pclk); n++; end
    if (n >= 20) begin error_cnt++; stop_test(); end
    rd = prdata; rd_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
endtask
task automatic poll(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    apb(1'b0, `OFS_GEN_STATUS, 32'h0);
    while ((rd[7:0] & m) !== v && n < 30) begin apb(1'b0, `OFS_GEN_STATUS, 32'h0); n++; end
    `chk(rd[7:0] & m, v)
    repeat (2) @(posedge pclk);
endtask
////////////////////////////////////////////////////////////////////////
task reset_check;
    apb(1'b0, `OFS_SOURCE_DIV, 32'h0); `chk(rd, 32'h04)
    apb(1'b0, `OFS_OSC_BUS, 32'h0); `chk(rd, 32'h40)
    apb(1'b0, `OFS_GEN_STATUS, 32'h0); `chk(rd, 32'h10)
    `chk(clock_mode, clock_mode_pkg::fll_engaged_internal)
    apb(1'b0, 8'h10, 32'h0); `chk(rd_err, 1'b1)
endtask
task to_fbe;
    apb(1'b1, `OFS_OSC_BUS, 32'h36);
    repeat (2) @(posedge pclk);
    `chk({osc_high_range, osc_high_gain, bus_divider}, 4'hC)
    `chk({ext_source_crystal, ext_refclk_active}, 2'h3)
    poll(8'h02, 8'h00);
    osc_stable <= 1'b1;
    poll(8'h02, 8'h02);
    apb(1'b1, `OFS_SOURCE_DIV, 32'hB8);
    poll(8'h1C, 8'h08);
    `chk({generator_source, loop_ref_internal, fll_enable}, 4'h9)
    `chk(ref_divide_ratio, 8'h80)
    fll_locked <= 1'b1;
    poll(8'h40, 8'h40);
endtask
task to_pee;
    apb(1'b1, `OFS_OSC_BUS, 32'h3E);
    repeat (3) @(posedge pclk);
    `chk(clock_mode, clock_mode_pkg::lowpower_bypass_external)
    apb(1'b1, `OFS_SOURCE_DIV, 32'h90);
    apb(1'b1, `OFS_LOOP_MULT, 32'h44);
    apb(1'b0, `OFS_LOOP_MULT, 32'h0); `chk(rd, 32'h44)
    `chk({fll_enable, pll_enable, ref_divide_ratio}, 10'h080)
    apb(1'b1, `OFS_OSC_BUS, 32'h36);
    poll(8'h20, 8'h20);
    `chk({ref_divide_ratio, pll_mult_factor}, 16'h0410)
    `chk(clock_mode, clock_mode_pkg::pll_bypassed_external)
    pll_locked <= 1'b1;
    poll(8'h40, 8'h40);
    apb(1'b1, `OFS_SOURCE_DIV, 32'h10);
    poll(8'h0C, 8'h0C);
    `chk(clock_mode, clock_mode_pkg::pll_engaged_external)
endtask
task to_lowpower_bypass_internal;
    apb(1'b1, `OFS_SOURCE_DIV, 32'h90);
    poll(8'h0C, 8'h08);
    apb(1'b1, `OFS_LOOP_MULT, 32'h04);
    poll(8'h20, 8'h00);
    `chk(pll_mult_factor, 8'h00)
    apb(1'b1, `OFS_SOURCE_DIV, 32'h44);
    poll(8'h1C, 8'h14);
    `chk({ref_divide_ratio, fll_enable}, 9'h003)
    apb(1'b1, `OFS_OSC_BUS, 32'h08);
    repeat (3) @(posedge pclk);
    `chk(clock_mode, clock_mode_pkg::lowpower_bypass_internal)
    `chk(fll_enable, 1'b0)
    // Reserved source code must leave the output source alone
    apb(1'b1, `OFS_SOURCE_DIV, 32'hC4);
    repeat (8) @(posedge pclk);
    poll(8'h0C, 8'h04);
endtask
task to_fee;
    apb(1'b1, `OFS_OSC_BUS, 32'h36);
    poll(8'h0C, 8'h04);
    apb(1'b1, `OFS_SOURCE_DIV, 32'h38);
    poll(8'h1C, 8'h00);
    `chk(clock_mode, clock_mode_pkg::fll_engaged_external)
endtask
initial begin
    error_cnt = 0; compares = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    osc_stable = 1'b0; fll_locked = 1'b0; pll_locked = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reset_check();
    to_fbe();
    to_pee();
    to_lowpower_bypass_internal();
    to_fee();
    stop_test();
end
endmodule
